//--- src/muc_regs.svh
// register offsets, control bits, limits and timing counts of the usage counters
`ifndef MUC_REGS_SVH
`define MUC_REGS_SVH
// printed offsets are register indexes; byte address is four times
`define MUC_IDX_OP_HOURS 16'h004c
`define MUC_IDX_FAN_HOURS 16'h0067
`define MUC_IDX_RUN_COUNT 16'h0076
`define MUC_IDX_CAP_LIFE 16'h007c
`define MUC_IDX_SW_LIFE 16'h07d7
`define MUC_IDX_FAULT9 16'h0812
`define MUC_IDX_FAULT10 16'h0813
`define MUC_IDX_FAULT8 16'h811e
// control registers placed in free space
`define MUC_IDX_CTRL 16'h0900
`define MUC_IDX_OP_PRESET 16'h0901
`define MUC_IDX_FAN_PRESET 16'h0902
`define MUC_IDX_CAP_SET 16'h0903
`define MUC_IDX_SW_SET 16'h0904
`define MUC_IDX_OUT_SEL 16'h0905
`define MUC_IDX_OP_HI 16'h0906
`define MUC_IDX_IRQ_STAT 16'h0907
`define MUC_IDX_IRQ_CLR 16'h0908
`define MUC_IDX_IRQ_EN 16'h0909
// ctrl bits
`define MUC_CTRL_SEL_RUN 0
`define MUC_CTRL_RUN_CLR 1
`define MUC_CTRL_CAP_CLR 2
`define MUC_CTRL_SW_CLR 3
// limits and thresholds
`define MUC_OP_MAX 17'd99999
`define MUC_CNT_MAX 16'hffff
`define MUC_SW_WARN 16'd50
`define MUC_SW_ALARM 16'd90
`define MUC_FUNC_WARN 8'h2f
`define MUC_FUNC_ALARM 8'h10
// timing
`define MUC_CLK_HZ 64'd10000000
`define MUC_HOUR_S 64'd3600
`endif

//--- src/muc_pkg.sv
// types of the usage counters
package muc_pkg;
    typedef struct packed {
        logic [16:0] op_hours;
        logic [15:0] run_count;
        logic [15:0] fan_hours;
        logic [15:0] cap_life;
        logic [15:0] sw_life;
        logic [16:0] fault8;
        logic [16:0] fault9;
        logic [16:0] fault10;
    } muc_counters_type;

    typedef struct packed {
        muc_counters_type cnt;
        logic [35:0] presc;
        logic sel_run;
        logic [7:0] out_sel0;
        logic [7:0] out_sel1;
        logic [2:0] run_sync;
        logic [1:0] fan_sync;
        logic [2:0] flt_sync;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [31:0] prdata;
        logic pready;
        logic irq;
        logic [1:0] contact;
    } muc_state_type;
endpackage

//--- src/muc_usage_counters.sv
// maintenance usage counters with apb register access
// How it works
// - operation hours count to 99999 then wrap to zero
// - software preset replaces the operation hour count
// - ctrl bit selects counting always or only while running
// - run command rising edges counted, wrap after 65535
// - run count cleared by its software clear bit
// - fan hours accumulate from settable start, wrap after 65535
// - capacitor life percent reported, cleared by its clear bit
// - transistor life percent reported in whole percent
// - function 2f closes at 50 percent, function 10 at 90
// - transistor life cleared by its clear bit
// - fault slots 8..10 hold op hours captured at faults
`timescale 1ns/1ps
`include "muc_regs.svh"
module muc_usage_counters #(
    parameter logic [35:0] HOUR_CYCLES =
        36'(`MUC_CLK_HZ * `MUC_HOUR_S)
) (
    input wire logic mclk, // system clock 10 mhz
    input wire logic rst, // async reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic run_cmd, // run command pin
    input wire logic fan_on, // cooling fan running pin
    input wire logic fault_evt, // fault occurred pin
    input wire logic cap_pct_tick, // capacitor life step, same clock
    input wire logic sw_pct_tick, // transistor life step, same clock
    output logic [1:0] contact_out, // contact outputs 0 and 1
    output logic irq // level interrupt
);
    muc_pkg::muc_state_type s_q, s_d;

    // word index from byte address
    function automatic logic [15:0] idx_of(input logic [31:0] a);
        idx_of = a[17:2];
    endfunction

    // contact closed when its function is met
    function automatic logic contact_of(input logic [7:0] f,
                                        input logic [15:0] pct);
        contact_of = (f == `MUC_FUNC_WARN && pct >= `MUC_SW_WARN) ||
                     (f == `MUC_FUNC_ALARM && pct >= `MUC_SW_ALARM);
    endfunction

    logic wr, rd, tick, run_rise, flt_rise, mapped;
    logic [15:0] idx;
    logic [31:0] rdv;

    // next state
    always_comb
    begin
        s_d = s_q;
        // writes land in the access cycle, reads decoded in setup
        wr = psel && penable && pwrite && s_q.pready;
        rd = psel && !penable && !pwrite;
        idx = idx_of(paddr);
        // synchronisers: stage 0 read only by stage 1
        s_d.run_sync = {s_q.run_sync[1:0], run_cmd};
        s_d.fan_sync = {s_q.fan_sync[0], fan_on};
        s_d.flt_sync = {s_q.flt_sync[1:0], fault_evt};
        run_rise = s_q.run_sync[1] && !s_q.run_sync[2];
        flt_rise = s_q.flt_sync[1] && !s_q.flt_sync[2];
        // hour prescaler
        tick = (s_q.presc == HOUR_CYCLES - 36'd1);
        s_d.presc = tick ? 36'd0 : s_q.presc + 36'd1;
        // operation hours
        if (tick && (!s_q.sel_run || s_q.run_sync[1]))
        begin
            s_d.cnt.op_hours = (s_q.cnt.op_hours >= `MUC_OP_MAX) ?
                17'd0 : s_q.cnt.op_hours + 17'd1;
        end
        if (tick && s_q.fan_sync[1])
        begin
            s_d.cnt.fan_hours = s_q.cnt.fan_hours + 16'd1;
        end
        if (run_rise)
        begin
            s_d.cnt.run_count = s_q.cnt.run_count + 16'd1;
        end
        if (cap_pct_tick && s_q.cnt.cap_life != `MUC_CNT_MAX)
        begin
            s_d.cnt.cap_life = s_q.cnt.cap_life + 16'd1;
        end
        if (sw_pct_tick && s_q.cnt.sw_life != `MUC_CNT_MAX)
        begin
            s_d.cnt.sw_life = s_q.cnt.sw_life + 16'd1;
        end
        // fault history shifts, newest into slot 8
        if (flt_rise)
        begin
            s_d.cnt.fault10 = s_q.cnt.fault9;
            s_d.cnt.fault9 = s_q.cnt.fault8;
            s_d.cnt.fault8 = s_q.cnt.op_hours;
        end
        // register writes
        if (wr)
        begin
            case (idx)
                `MUC_IDX_CTRL:
                begin
                    s_d.sel_run = pwdata[`MUC_CTRL_SEL_RUN];
                    if (pwdata[`MUC_CTRL_RUN_CLR])
                        s_d.cnt.run_count = 16'h0000;
                    if (pwdata[`MUC_CTRL_CAP_CLR])
                        s_d.cnt.cap_life = 16'h0000;
                    if (pwdata[`MUC_CTRL_SW_CLR])
                        s_d.cnt.sw_life = 16'h0000;
                end
                `MUC_IDX_OP_PRESET:
                    s_d.cnt.op_hours = (pwdata[16:0] > `MUC_OP_MAX) ?
                        `MUC_OP_MAX : pwdata[16:0];
                `MUC_IDX_FAN_PRESET:
                    s_d.cnt.fan_hours = pwdata[15:0];
                `MUC_IDX_CAP_SET:
                    s_d.cnt.cap_life = pwdata[15:0];
                `MUC_IDX_SW_SET:
                    s_d.cnt.sw_life = pwdata[15:0];
                `MUC_IDX_OUT_SEL:
                begin
                    s_d.out_sel0 = pwdata[7:0];
                    s_d.out_sel1 = pwdata[15:8];
                end
                `MUC_IDX_IRQ_EN:
                    s_d.irq_en = pwdata[3:0];
                default:
                    s_d.irq_en = s_q.irq_en;
            endcase
        end
        // sticky events: set wins over clear
        if (wr && idx == `MUC_IDX_IRQ_CLR)
            s_d.irq_stat = s_q.irq_stat & ~pwdata[3:0];
        s_d.irq_stat = s_d.irq_stat |
            {s_q.cnt.sw_life < `MUC_SW_ALARM &&
                 s_d.cnt.sw_life >= `MUC_SW_ALARM,
             s_q.cnt.sw_life < `MUC_SW_WARN &&
                 s_d.cnt.sw_life >= `MUC_SW_WARN,
             flt_rise, tick};
        // readback
        mapped = 1'b1;
        case (idx)
            `MUC_IDX_OP_HOURS: rdv = {16'h0000, s_q.cnt.op_hours[15:0]};
            `MUC_IDX_OP_HI: rdv = {31'h0, s_q.cnt.op_hours[16]};
            `MUC_IDX_FAN_HOURS: rdv = {16'h0000, s_q.cnt.fan_hours};
            `MUC_IDX_RUN_COUNT: rdv = {16'h0000, s_q.cnt.run_count};
            `MUC_IDX_CAP_LIFE: rdv = {16'h0000, s_q.cnt.cap_life};
            `MUC_IDX_SW_LIFE: rdv = {16'h0000, s_q.cnt.sw_life};
            `MUC_IDX_FAULT8: rdv = {15'h0, s_q.cnt.fault8};
            `MUC_IDX_FAULT9: rdv = {15'h0, s_q.cnt.fault9};
            `MUC_IDX_FAULT10: rdv = {15'h0, s_q.cnt.fault10};
            `MUC_IDX_CTRL: rdv = {31'h0, s_q.sel_run};
            `MUC_IDX_OUT_SEL: rdv = {16'h0000, s_q.out_sel1, s_q.out_sel0};
            `MUC_IDX_IRQ_STAT: rdv = {28'h0, s_q.irq_stat};
            `MUC_IDX_IRQ_EN: rdv = {28'h0, s_q.irq_en};
            `MUC_IDX_OP_PRESET, `MUC_IDX_FAN_PRESET, `MUC_IDX_CAP_SET,
            `MUC_IDX_SW_SET, `MUC_IDX_IRQ_CLR: rdv = 32'h0000_0000;
            default:
            begin
                rdv = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
        s_d.prdata = rd ? rdv : 32'h0000_0000;
        s_d.pready = psel && !penable; // answer in first access cycle
        s_d.irq = |(s_d.irq_stat & s_d.irq_en);
        s_d.contact = {contact_of(s_d.out_sel1, s_d.cnt.sw_life),
                       contact_of(s_d.out_sel0, s_d.cnt.sw_life)};
        s_d.presc = s_d.presc;
        s_d.cnt.run_count = s_d.cnt.run_count;
        s_d.cnt.fan_hours = s_d.cnt.fan_hours;
        s_d.cnt.cap_life = s_d.cnt.cap_life;
        s_d.sel_run = s_d.sel_run;
        s_d.out_sel0 = s_d.out_sel0;
        s_d.pready = s_d.pready;
        s_d.irq_en = s_d.irq_en;
        s_d.irq = s_d.irq;
        s_d.prdata = s_d.prdata;
        s_d.contact = s_d.contact;
        s_d.cnt.fault8 = s_d.cnt.fault8;
        s_d.cnt = s_d.cnt;
        s_d.flt_sync = s_d.flt_sync;
        s_d.fan_sync = s_d.fan_sync;
        s_d.run_sync = s_d.run_sync;
        s_d.irq_stat = s_d.irq_stat;
        s_d.out_sel1 = s_d.out_sel1;
        s_d.cnt.sw_life = s_d.cnt.sw_life;
        s_d.cnt.op_hours = s_d.cnt.op_hours;
        s_d.cnt.fault9 = s_d.cnt.fault9;
        s_d.cnt.fault10 = s_d.cnt.fault10;
        mapped = mapped;
    end

    // state register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    logic err_q;
    // error flag for unmapped access
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            err_q <= 1'b0;
        else
            err_q <= psel && !penable && !mapped;
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = err_q;
    assign irq = s_q.irq;
    assign contact_out = s_q.contact;

    // bus handshake: ready one cycle after setup, data only with it
    AST_READY_SETUP: assert property (
        @(posedge mclk) disable iff (rst)
        psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (
        @(posedge mclk) disable iff (rst)
        pready |=> !pready)
        else $error("ready held too long");
    AST_READ_IDLE: assert property (
        @(posedge mclk) disable iff (rst)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    AST_ERR_READY: assert property (
        @(posedge mclk) disable iff (rst)
        pslverr |-> pready)
        else $error("error flag without ready");

    // hour prescaler
    AST_PRESC_RANGE: assert property (
        @(posedge mclk) disable iff (rst)
        s_q.presc < HOUR_CYCLES)
        else $error("prescaler out of range");
    AST_TICK_GAP: assert property (
        @(posedge mclk) disable iff (rst)
        tick |=> !tick)
        else $error("hour ticks back to back");

    // operation hours
    AST_OP_WRAP: assert property (
        @(posedge mclk) disable iff (rst)
        s_q.cnt.op_hours <= `MUC_OP_MAX)
        else $error("op hours above limit");
    AST_OP_STEP: assert property (
        @(posedge mclk) disable iff (rst)
        !(wr && idx == `MUC_IDX_OP_PRESET) && s_q.cnt.op_hours ==
        `MUC_OP_MAX && tick && (!s_q.sel_run || s_q.run_sync[1])
        |=> s_q.cnt.op_hours == 17'd0)
        else $error("op hours did not wrap");
    AST_OP_COUNT: assert property (
        @(posedge mclk) disable iff (rst)
        !(wr && idx == `MUC_IDX_OP_PRESET) && s_q.cnt.op_hours <
        `MUC_OP_MAX && tick && (!s_q.sel_run || s_q.run_sync[1])
        |=> s_q.cnt.op_hours == $past(s_q.cnt.op_hours) + 17'd1)
        else $error("op hours did not step");
    AST_OP_PRESET: assert property (
        @(posedge mclk) disable iff (rst)
        wr && idx == `MUC_IDX_OP_PRESET && pwdata[16:0] <= `MUC_OP_MAX
        |=> s_q.cnt.op_hours == $past(pwdata[16:0]))
        else $error("op preset not taken");
    AST_OP_HOLD: assert property (
        @(posedge mclk) disable iff (rst)
        !tick && !(wr && idx == `MUC_IDX_OP_PRESET)
        |=> $stable(s_q.cnt.op_hours))
        else $error("op hours moved without tick");
    AST_SEL_RUN: assert property (
        @(posedge mclk) disable iff (rst)
        tick && s_q.sel_run && !s_q.run_sync[1] &&
        !(wr && idx == `MUC_IDX_OP_PRESET) |=> $stable(s_q.cnt.op_hours))
        else $error("op counted while stopped");
    AST_SEL_TAKE: assert property (
        @(posedge mclk) disable iff (rst)
        wr && idx == `MUC_IDX_CTRL
        |=> s_q.sel_run == $past(pwdata[`MUC_CTRL_SEL_RUN]))
        else $error("count select not taken");

    // cooling fan hours
    AST_FAN_STEP: assert property (
        @(posedge mclk) disable iff (rst)
        tick && s_q.fan_sync[1] && !(wr && idx == `MUC_IDX_FAN_PRESET)
        |=> s_q.cnt.fan_hours == $past(s_q.cnt.fan_hours) + 16'd1)
        else $error("fan hours did not step");
    AST_FAN_PRESET: assert property (
        @(posedge mclk) disable iff (rst)
        wr && idx == `MUC_IDX_FAN_PRESET
        |=> s_q.cnt.fan_hours == $past(pwdata[15:0]))
        else $error("fan preset not taken");
    AST_FAN_HOLD: assert property (
        @(posedge mclk) disable iff (rst)
        !tick && !(wr && idx == `MUC_IDX_FAN_PRESET)
        |=> $stable(s_q.cnt.fan_hours))
        else $error("fan hours moved without tick");

    // run commands
    AST_RUN_INC: assert property (
        @(posedge mclk) disable iff (rst)
        run_rise && !wr |=> s_q.cnt.run_count ==
        $past(s_q.cnt.run_count) + 16'd1)
        else $error("run count missed");
    AST_RUN_CLR: assert property (
        @(posedge mclk) disable iff (rst)
        wr && idx == `MUC_IDX_CTRL && pwdata[`MUC_CTRL_RUN_CLR]
        |=> s_q.cnt.run_count == 16'h0000)
        else $error("run count not cleared");

    // life percentages and contacts
    AST_CAP_STEP: assert property (
        @(posedge mclk) disable iff (rst)
        cap_pct_tick && !wr && s_q.cnt.cap_life != `MUC_CNT_MAX
        |=> s_q.cnt.cap_life == $past(s_q.cnt.cap_life) + 16'd1)
        else $error("capacitor life did not step");
    AST_CAP_CLR: assert property (
        @(posedge mclk) disable iff (rst)
        wr && idx == `MUC_IDX_CTRL && pwdata[`MUC_CTRL_CAP_CLR]
        |=> s_q.cnt.cap_life == 16'h0000)
        else $error("capacitor life not cleared");
    AST_SW_STEP: assert property (
        @(posedge mclk) disable iff (rst)
        sw_pct_tick && !wr && s_q.cnt.sw_life != `MUC_CNT_MAX
        |=> s_q.cnt.sw_life == $past(s_q.cnt.sw_life) + 16'd1)
        else $error("transistor life did not step");
    AST_SW_CLR: assert property (
        @(posedge mclk) disable iff (rst)
        wr && idx == `MUC_IDX_CTRL && pwdata[`MUC_CTRL_SW_CLR]
        |=> s_q.cnt.sw_life == 16'h0000)
        else $error("transistor life not cleared");
    AST_CONTACT0: assert property (
        @(posedge mclk) disable iff (rst)
        contact_out[0] ==
        ((s_q.out_sel0 == `MUC_FUNC_WARN && s_q.cnt.sw_life >= `MUC_SW_WARN)
        || (s_q.out_sel0 == `MUC_FUNC_ALARM &&
        s_q.cnt.sw_life >= `MUC_SW_ALARM)))
        else $error("contact 0 wrong");
    AST_CONTACT1: assert property (
        @(posedge mclk) disable iff (rst)
        contact_out[1] ==
        ((s_q.out_sel1 == `MUC_FUNC_WARN && s_q.cnt.sw_life >= `MUC_SW_WARN)
        || (s_q.out_sel1 == `MUC_FUNC_ALARM &&
        s_q.cnt.sw_life >= `MUC_SW_ALARM)))
        else $error("contact 1 wrong");

    // fault history
    AST_FAULT: assert property (
        @(posedge mclk) disable iff (rst)
        flt_rise |=> s_q.cnt.fault8 == $past(s_q.cnt.op_hours) &&
        s_q.cnt.fault9 == $past(s_q.cnt.fault8))
        else $error("fault slot not captured");
    AST_FAULT_OLD: assert property (
        @(posedge mclk) disable iff (rst)
        flt_rise |=> s_q.cnt.fault10 == $past(s_q.cnt.fault9))
        else $error("oldest fault slot not shifted");
    AST_FAULT_HOLD: assert property (
        @(posedge mclk) disable iff (rst)
        !flt_rise |=> $stable(s_q.cnt.fault8) && $stable(s_q.cnt.fault9) &&
        $stable(s_q.cnt.fault10))
        else $error("fault slot moved without fault");
    AST_FAULT_FLAG: assert property (
        @(posedge mclk) disable iff (rst)
        flt_rise |=> s_q.irq_stat[1])
        else $error("fault event flag not set");
endmodule

//--- sim/testbench.sv
// self-checking bench of the maintenance usage counters
`timescale 1ns/1ps
`include "muc_regs.svh"
module testbench;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, run_cmd = 1'b0, fan_on = 1'b0, fault_evt = 1'b0;
    logic cap_pct_tick = 1'b0, sw_pct_tick = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
    logic pready, pslverr, irq, e;
    logic [1:0] contact_out;
    int n_errors = 0;
    int cmp_count = 0;
    // device under test with a short hour
    muc_usage_counters #(.HOUR_CYCLES(36'd20)) u_muc_usage_counters (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
        .fan_on(fan_on), .fault_evt(fault_evt),
        .cap_pct_tick(cap_pct_tick), .sw_pct_tick(sw_pct_tick),
        .contact_out(contact_out), .irq(irq));
    // 10 mhz clock
    always #50 mclk = ~mclk;
    task results();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex)
        begin
            $display("unexpected %s expected %h seen %h", nm, ex, seen);
            n_errors++;
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
             output logic [31:0] rd, output logic er);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20)
            chk("pready", 1'b0, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, r, e);
    endtask
    task rd(input logic [15:0] idx);
        apb(1'b0, idx, 32'h0, r, e);
    endtask
    // read until the value leaves old
    task poll(input logic [15:0] idx, input logic [31:0] old);
        int n;
        n = 0;
        do
        begin
            rd(idx);
            n++;
        end
        while (r === old && n < 30);
    endtask
    task pulse_fault();
        fault_evt <= 1'b1;
        repeat (5) @(posedge mclk);
        fault_evt <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask
    task t_reset();
        rd(`MUC_IDX_OP_HOURS);
        chk("op_rst", r, 32'h0);
        rd(`MUC_IDX_RUN_COUNT);
        chk("run_rst", r, 32'h0);
        repeat (45) @(posedge mclk);
        rd(`MUC_IDX_OP_HOURS);
        chk("op_free", {31'h0, r != 32'h0}, 32'h1);
    endtask
    task t_op();
        wr(`MUC_IDX_CTRL, 32'h1);
        wr(`MUC_IDX_OP_PRESET, 32'd99999);
        rd(`MUC_IDX_OP_HOURS);
        chk("op_preset", r, 32'h869f);
        rd(`MUC_IDX_OP_HI);
        chk("op_hi", r, 32'h1);
        repeat (50) @(posedge mclk);
        rd(`MUC_IDX_OP_HOURS);
        chk("op_idle", r, 32'h869f);
        run_cmd <= 1'b1;
        poll(`MUC_IDX_OP_HOURS, 32'h869f);
        run_cmd <= 1'b0;
        chk("op_wrap", r, 32'h0);
        rd(`MUC_IDX_OP_HI);
        chk("op_hi_wrap", r, 32'h0);
        rd(`MUC_IDX_RUN_COUNT);
        chk("run_count", r, 32'h1);
        wr(`MUC_IDX_CTRL, 32'h3);
        rd(`MUC_IDX_RUN_COUNT);
        chk("run_clear", r, 32'h0);
    endtask
    task t_fan();
        wr(`MUC_IDX_FAN_PRESET, 32'hffff);
        rd(`MUC_IDX_FAN_HOURS);
        chk("fan_preset", r, 32'hffff);
        fan_on <= 1'b1;
        poll(`MUC_IDX_FAN_HOURS, 32'hffff);
        fan_on <= 1'b0;
        chk("fan_wrap", r, 32'h0);
    endtask
    task t_cap();
        wr(`MUC_IDX_CAP_SET, 32'h10);
        repeat (3)
        begin
            @(posedge mclk) cap_pct_tick <= 1'b1;
            @(posedge mclk) cap_pct_tick <= 1'b0;
        end
        rd(`MUC_IDX_CAP_LIFE);
        chk("cap_life", r, 32'h13);
        wr(`MUC_IDX_CTRL, 32'h5);
        rd(`MUC_IDX_CAP_LIFE);
        chk("cap_clear", r, 32'h0);
    endtask
    // step transistor life from just under a threshold
    task sw_step(input logic [31:0] start, input logic [1:0] ex);
        wr(`MUC_IDX_SW_SET, start);
        @(posedge mclk) sw_pct_tick <= 1'b1;
        @(posedge mclk) sw_pct_tick <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(`MUC_IDX_SW_LIFE);
        chk("sw_life", r, start + 32'h1);
        chk("contact", {30'h0, contact_out}, {30'h0, ex});
    endtask
    task t_sw();
        wr(`MUC_IDX_OUT_SEL, 32'h102f);
        wr(`MUC_IDX_SW_SET, 32'd48);
        repeat (4) @(posedge mclk);
        chk("contact_low", {30'h0, contact_out}, 32'h0);
        sw_step(32'd48, 2'b00);
        sw_step(32'd49, 2'b01);
        sw_step(32'd89, 2'b11);
        rd(`MUC_IDX_IRQ_STAT);
        chk("irq_cross", r & 32'hc, 32'hc);
        wr(`MUC_IDX_CTRL, 32'h9);
        rd(`MUC_IDX_SW_LIFE);
        chk("sw_clear", r, 32'h0);
        repeat (4) @(posedge mclk);
        chk("contact_clr", {30'h0, contact_out}, 32'h0);
    endtask
    task t_fault();
        wr(`MUC_IDX_IRQ_CLR, 32'hf);
        wr(`MUC_IDX_IRQ_EN, 32'h2);
        wr(`MUC_IDX_OP_PRESET, 32'd7);
        pulse_fault();
        rd(`MUC_IDX_FAULT8);
        chk("fault8", r, 32'd7);
        chk("irq_on", {31'h0, irq}, 32'h1);
        rd(`MUC_IDX_IRQ_STAT);
        chk("irq_stat", {31'h0, r[1]}, 32'h1);
        wr(`MUC_IDX_IRQ_CLR, 32'h2);
        repeat (3) @(posedge mclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        wr(`MUC_IDX_IRQ_EN, 32'h0);
        wr(`MUC_IDX_OP_PRESET, 32'd8);
        pulse_fault();
        chk("irq_mask", {31'h0, irq}, 32'h0);
        rd(`MUC_IDX_FAULT8);
        chk("fault8_new", r, 32'd8);
        rd(`MUC_IDX_FAULT9);
        chk("fault9", r, 32'd7);
        rd(`MUC_IDX_FAULT10);
        chk("fault10", r, 32'd0);
    endtask
    task t_unmapped();
        apb(1'b0, 16'h0001, 32'h0, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        chk("unmapped_data", r, 32'h0);
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_op();
        t_fan();
        t_cap();
        t_sw();
        t_fault();
        t_unmapped();
        results();
    end
    // watchdog against a hang
    initial
    begin
        #(100 * 30000);
        n_errors++;
        results();
    end
endmodule
